/* File: bcc_clock.sv */
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
// Contract
// - BCD counters for century, year, month, date, day, hour, minute, second
// - Years 1900 to 2099; century rolls when year passes 99
// - Hours in 24-hour or 12-hour form with AM/PM, by setting
// - Every year divisible by 4 is leap; February then has 29 days
// - Seconds advance each second; higher counters on carry
// - Five alarm fields, each with its own enable bit
// - All enabled fields matching sets alarm flag and interrupt if enabled
// - Only seconds field enabled gives one alarm per minute
// - Invalid time or calendar write ignored; flag set until valid write
// - Alarm writes checked the same way with their own flags
// - Century only 19 or 20; year must be legal BCD
// - Date 01-31, month 01-12, date must exist in that month
// - Day of week only 1 to 7
// - Hours BCD; 00-23 with AM/PM clear, or 01-12 in 12-hour
// - Minutes and seconds legal BCD 00 to 59
// - AM/PM bit 22 picks the range; readback is 24-hour value
// - Update acknowledge flag set; host clears it by writing one
// - Time keeps running during a calendar-only update
// - Fields load from one whole 32-bit write at once
// - Time request halts time; time loads only while it is set
module bcc_clock #(
   parameter int TICK_CYCLES = bcc_pkg::BCC_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        srst,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // Interrupt
   output logic             irq
);
   import bcc_pkg::*;

   logic [BCC_TICK_W-1:0] div_reg;
   logic                  tick, tick_d_reg, midnight;
   logic                  upd_time_reg, upd_cal_reg, hr12_reg;
   logic [6:0]            sec_reg, min_reg, cent_reg;
   logic [5:0]            hour_reg, date_reg;
   logic [7:0]            year_reg;
   logic [4:0]            month_reg;
   logic [2:0]            day_reg;
   logic [6:0]            asec_reg, amin_reg;
   logic [5:0]            ahour_reg, adate_reg;
   logic [4:0]            amonth_reg;
   logic [4:0]            aen_reg;
   logic [1:0]            stat_reg, imask_reg;
   logic [3:0]            valid_reg;
   logic                  wr_ctrl, wr_time, wr_cal, wr_tm, wr_cm;
   logic                  time_ok, cal_ok, tm_ok, cm_ok;
   logic                  ack_set, alarm_hit;
   logic [5:0]            w_hour24, w_ahour24;

   // BCD value with legal units and within lo..hi
   function automatic logic bcd_in(input logic [7:0] v, input logic [7:0] lo,
                                   input logic [7:0] hi);
      return (v[3:0] <= 4'h9) && (v >= lo) && (v <= hi);
   endfunction

   // BCD increment by one
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
   endfunction

   // Leap test of a BCD year, divisible by 4
   function automatic logic leap(input logic [7:0] y);
      if (y[4])
         return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      else
         return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
   endfunction

   // Last date of a month in BCD
   function automatic logic [7:0] mdays(input logic [4:0] m, input logic lp);
      if (m == 5'h02)
         return lp ? 8'h29 : 8'h28;
      else if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11)
         return 8'h30;
      else
         return 8'h31;
   endfunction

   // Hour legality in the selected mode
   function automatic logic hour_ok(input logic [5:0] h, input logic pm,
                                    input logic h12);
      if (h12)
         return bcd_in(8'(h), 8'h01, 8'h12);
      else
         return bcd_in(8'(h), 8'h00, 8'h23) && !pm;
   endfunction

   // 12-hour entry to 24-hour BCD
   function automatic logic [5:0] to24(input logic [5:0] h, input logic pm,
                                       input logic h12);
      logic [4:0] b;
      logic [4:0] c;
      b = 5'(h[5:4]) * 5'd10 + 5'(h[3:0]);
      if (!h12)
         c = b;
      else if (b == 5'd12)
         c = pm ? 5'd12 : 5'd0;
      else
         c = pm ? b + 5'd12 : b;
      if (c >= 5'd20)
         return {2'd2, 4'(c - 5'd20)};
      else if (c >= 5'd10)
         return {2'd1, 4'(c - 5'd10)};
      else
         return {2'd0, c[3:0]};
   endfunction

   // Address decode of writes
   assign wr_ctrl = reg_wr && (reg_addr == BCC_CTRL_OFS);
   assign wr_time = reg_wr && (reg_addr == BCC_TIME_OFS);
   assign wr_cal  = reg_wr && (reg_addr == BCC_CAL_OFS);
   assign wr_tm   = reg_wr && (reg_addr == BCC_TMATCH_OFS);
   assign wr_cm   = reg_wr && (reg_addr == BCC_CMATCH_OFS);

   assign time_ok = bcd_in(8'(reg_wdata[6:0]), 8'h00, 8'h59)
                 && bcd_in(8'(reg_wdata[14:8]), 8'h00, 8'h59)
                 && hour_ok(reg_wdata[21:16], reg_wdata[BCC_AMPM_BIT], hr12_reg);
   assign cal_ok = (reg_wdata[6:0] == 7'h19 || reg_wdata[6:0] == 7'h20)
                && bcd_in(reg_wdata[15:8], 8'h00, 8'h99)
                && bcd_in(8'(reg_wdata[20:16]), 8'h01, 8'h12)
                && bcd_in(8'(reg_wdata[29:24]), 8'h01,
                          mdays(reg_wdata[20:16], leap(reg_wdata[15:8])))
                && (reg_wdata[23:21] != 3'd0);
   assign tm_ok = time_ok;
   assign cm_ok = bcd_in(8'(reg_wdata[20:16]), 8'h01, 8'h12)
               && bcd_in(8'(reg_wdata[29:24]), 8'h01,
                         mdays(reg_wdata[20:16], 1'b1));
   assign w_hour24  = to24(reg_wdata[21:16], reg_wdata[BCC_AMPM_BIT], hr12_reg);
   assign w_ahour24 = w_hour24;

   // Second tick divider
   assign tick = (div_reg == BCC_TICK_W'(TICK_CYCLES - 1));
   always_ff @(posedge clk_sys) begin
      if (srst || tick)
         div_reg <= '0;
      else
         div_reg <= div_reg + 1'b1;
   end

   // Delayed tick for alarm compare
   always_ff @(posedge clk_sys) begin
      if (srst)
         tick_d_reg <= 1'b0;
      else
         tick_d_reg <= tick;
   end

   // Control and hour mode
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         upd_time_reg <= 1'b0;
         upd_cal_reg  <= 1'b0;
         hr12_reg     <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            upd_time_reg <= reg_wdata[BCC_UPD_TIME_BIT];
            upd_cal_reg  <= reg_wdata[BCC_UPD_CAL_BIT];
         end
         if (reg_wr && reg_addr == BCC_HMODE_OFS)
            hr12_reg <= reg_wdata[0];
      end
   end

   assign midnight = tick && !upd_time_reg && sec_reg == 7'h59
                  && min_reg == 7'h59 && hour_reg == 6'h23;

   // Time counters
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sec_reg  <= BCC_TIME_RST[6:0];
         min_reg  <= BCC_TIME_RST[14:8];
         hour_reg <= BCC_TIME_RST[21:16];
      end else if (wr_time && upd_time_reg) begin
         if (time_ok) begin
            sec_reg  <= reg_wdata[6:0];
            min_reg  <= reg_wdata[14:8];
            hour_reg <= w_hour24;
         end
      end else if (tick && !upd_time_reg) begin
         if (sec_reg != 7'h59) begin
            sec_reg <= 7'(bcd_inc(8'(sec_reg)));
         end else begin
            sec_reg <= 7'h00;
            if (min_reg != 7'h59) begin
               min_reg <= 7'(bcd_inc(8'(min_reg)));
            end else begin
               min_reg  <= 7'h00;
               hour_reg <= (hour_reg == 6'h23) ? 6'h00 : 6'(bcd_inc(8'(hour_reg)));
            end
         end
      end
   end

   // Calendar counters
   // BCD calendar counters
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cent_reg  <= BCC_CAL_RST[6:0];
         year_reg  <= BCC_CAL_RST[15:8];
         month_reg <= BCC_CAL_RST[20:16];
         day_reg   <= BCC_CAL_RST[23:21];
         date_reg  <= BCC_CAL_RST[29:24];
      end else if (wr_cal && upd_cal_reg) begin
         if (cal_ok) begin
            cent_reg  <= reg_wdata[6:0];
            year_reg  <= reg_wdata[15:8];
            month_reg <= reg_wdata[20:16];
            day_reg   <= reg_wdata[23:21];
            date_reg  <= reg_wdata[29:24];
         end
      end else if (midnight && !upd_cal_reg) begin
         day_reg <= (day_reg == 3'd7) ? 3'd1 : day_reg + 3'd1;
         if (8'(date_reg) != mdays(month_reg, leap(year_reg))) begin
            date_reg <= 6'(bcd_inc(8'(date_reg)));
         end else begin
            date_reg <= 6'h01;
            if (month_reg != 5'h12) begin
               month_reg <= 5'(bcd_inc(8'(month_reg)));
            end else begin
               month_reg <= 5'h01;
               // century roll, 2099 wraps to 1900
               if (year_reg != 8'h99) begin
                  year_reg <= bcd_inc(year_reg);
               end else begin
                  year_reg <= 8'h00;
                  cent_reg <= (cent_reg == 7'h19) ? 7'h20 : 7'h19;
               end
            end
         end
      end
   end

   // Alarm fields and enables
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         asec_reg   <= '0;
         amin_reg   <= '0;
         ahour_reg  <= '0;
         amonth_reg <= '0;
         adate_reg  <= '0;
         aen_reg    <= '0;
      end else begin
         if (wr_tm && tm_ok) begin
            asec_reg   <= reg_wdata[6:0];
            amin_reg   <= reg_wdata[14:8];
            ahour_reg  <= w_ahour24;
            aen_reg[0] <= reg_wdata[BCC_SEC_EN_BIT];
            aen_reg[1] <= reg_wdata[BCC_MIN_EN_BIT];
            aen_reg[2] <= reg_wdata[BCC_HOUR_EN_BIT];
         end
         if (wr_cm && cm_ok) begin
            amonth_reg <= reg_wdata[20:16];
            adate_reg  <= reg_wdata[29:24];
            aen_reg[3] <= reg_wdata[BCC_MONTH_EN_BIT];
            aen_reg[4] <= reg_wdata[BCC_DATE_EN_BIT];
         end
      end
   end

   // Entry validity flags, cleared only by a good write
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         valid_reg <= '0;
      end else begin
         if (wr_time && upd_time_reg)
            valid_reg[BCC_VT_BIT] <= !time_ok;
         if (wr_cal && upd_cal_reg)
            valid_reg[BCC_VC_BIT] <= !cal_ok;
         if (wr_tm)
            valid_reg[BCC_VTA_BIT] <= !tm_ok;
         if (wr_cm)
            valid_reg[BCC_VCA_BIT] <= !cm_ok;
      end
   end

   assign alarm_hit = tick_d_reg && (aen_reg != 5'b0)
                   && (!aen_reg[0] || asec_reg == sec_reg)
                   && (!aen_reg[1] || amin_reg == min_reg)
                   && (!aen_reg[2] || ahour_reg == hour_reg)
                   && (!aen_reg[3] || amonth_reg == month_reg)
                   && (!aen_reg[4] || adate_reg == date_reg);

   assign ack_set = wr_ctrl && ((reg_wdata[BCC_UPD_TIME_BIT] && !upd_time_reg)
                             || (reg_wdata[BCC_UPD_CAL_BIT] && !upd_cal_reg));

   // Status flags; a set wins over a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         stat_reg <= '0;
      end else begin
         if (reg_wr && reg_addr == BCC_SCLR_OFS)
            stat_reg <= stat_reg & ~reg_wdata[1:0];
         if (ack_set)
            stat_reg[BCC_ACK_BIT] <= 1'b1;
         if (alarm_hit)
            stat_reg[BCC_ALARM_BIT] <= 1'b1;
      end
   end

   // Interrupt mask, set and cleared by separate writes
   always_ff @(posedge clk_sys) begin
      if (srst)
         imask_reg <= '0;
      else if (reg_wr && reg_addr == BCC_IEN_OFS)
         imask_reg <= imask_reg | reg_wdata[1:0];
      else if (reg_wr && reg_addr == BCC_IDIS_OFS)
         imask_reg <= imask_reg & ~reg_wdata[1:0];
   end

   always_ff @(posedge clk_sys) begin
      if (srst)
         irq <= 1'b0;
      else
         irq <= |(stat_reg & imask_reg);
   end

   // readback is a live snapshot
   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys) begin
      if (srst || !reg_rd) begin
         reg_rdata <= '0;
      end else begin
         unique case (reg_addr)
            BCC_CTRL_OFS:   reg_rdata <= {30'h0, upd_cal_reg, upd_time_reg};
            BCC_HMODE_OFS:  reg_rdata <= {31'h0, hr12_reg};
            BCC_TIME_OFS:   reg_rdata <= {10'h0, hour_reg, 1'b0, min_reg,
                                          1'b0, sec_reg};
            BCC_CAL_OFS:    reg_rdata <= {2'h0, date_reg, day_reg, month_reg,
                                          year_reg, 1'b0, cent_reg};
            BCC_TMATCH_OFS: reg_rdata <= {8'h0, aen_reg[2], 1'b0, ahour_reg,
                                          aen_reg[1], amin_reg, aen_reg[0], asec_reg};
            BCC_CMATCH_OFS: reg_rdata <= {aen_reg[4], 1'b0, adate_reg,
                                          aen_reg[3], 2'h0, amonth_reg, 16'h0};
            BCC_STAT_OFS:   reg_rdata <= {30'h0, stat_reg};
            BCC_IMASK_OFS:  reg_rdata <= {30'h0, imask_reg};
            BCC_VALID_OFS:  reg_rdata <= {28'h0, valid_reg};
            default:        reg_rdata <= '0;
         endcase
      end
   end

endmodule // bcc_clock

/* File: bcc_clock_monitor.sv */
`timescale 1ns/100ps
module bcc_clock_monitor #(
   parameter int TICK_CYCLES = 8
) (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        srst,
   // Register port
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Interrupt
   input wire logic        irq
);
   import bcc_pkg::*;
   logic       rd_q;
   logic [7:0] ra_q;
   logic       c_rd;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // Remember which register the data in flight belongs to
   always_ff @(posedge clk_sys) begin
      rd_q <= reg_rd & ~srst;
      ra_q <= reg_addr;
   end
   assign c_rd = rd_q && ra_q == BCC_CAL_OFS;
   // Read data only in the cycle after a read
   rdata_idle_a: assert property (!rd_q |-> reg_rdata == 32'h0)
      else $error("read data outside the read cycle");
   sec_min_bcd_a: assert property (reg_rd && reg_addr == BCC_TIME_OFS |=>
      reg_rdata[3:0] <= 4'h9 && reg_rdata[6:4] <= 3'h5
      && reg_rdata[11:8] <= 4'h9 && reg_rdata[14:12] <= 3'h5)
      else $error("seconds or minutes out of range");
   hour_read_24h_a: assert property (reg_rd && reg_addr == BCC_TIME_OFS |=>
      !reg_rdata[22] && reg_rdata[21:16] <= 6'h23 && reg_rdata[19:16] <= 4'h9)
      else $error("hour not a 24-hour value");
   cent_range_a: assert property (c_rd |-> reg_rdata[6:0] inside {7'h19, 7'h20})
      else $error("century out of range");
   year_bcd_a: assert property (c_rd |-> reg_rdata[11:8] <= 4'h9 && reg_rdata[15:12] <= 4'h9)
      else $error("year not BCD");
   month_date_a: assert property (c_rd |-> reg_rdata[20:16] inside {[5'h01:5'h09],
      [5'h10:5'h12]} && reg_rdata[29:24] inside {[6'h01:6'h09], [6'h10:6'h19],
      [6'h20:6'h29], [6'h30:6'h31]})
      else $error("month or date out of range");
   day_range_a: assert property (c_rd |-> reg_rdata[23:21] != 3'h0)
      else $error("day of week zero");
   valid_upper_a: assert property (rd_q && ra_q == BCC_VALID_OFS |-> reg_rdata[31:4] == 28'h0)
      else $error("validity word has stray bits");
   reset_quiet_a: assert property ($fell(srst) |-> !irq ##1 !irq)
      else $error("interrupt right after reset");
   // Main scenarios
   cover property (c_rd);
   cover property ($rose(irq));
   cover property (reg_wr && reg_addr == BCC_CTRL_OFS && reg_wdata[1:0] == 2'b11);
endmodule // bcc_clock_monitor

bind bcc_clock bcc_clock_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (.clk_sys(clk_sys),
   .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

/* File: bcc_host.sv */
`timescale 1ns/100ps
module bcc_host (
   // Clock
   input wire logic        clk_sys,
   // Register port
   output logic      [7:0]  reg_addr,
   output logic      [31:0] reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input wire logic [31:0]  reg_rdata
);
   import bcc_pkg::*;
   int gap = 0; // Idle cycles after each access
   // Quiet bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // One write, strobe low for a cycle after it
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      repeat (gap + 1) @(posedge clk_sys);
   endtask
   // One read, data taken at the end of the following cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      d = reg_rdata;
      repeat (gap) @(posedge clk_sys);
   endtask
   task automatic rd2(input logic [7:0] a, output logic [31:0] d);
      logic [31:0] p;
      rd(a, p);
      rd(a, d);
      if (d !== p) rd(a, d);
   endtask
   task automatic upd(input logic [1:0] m, output logic [31:0] s);
      s = 32'h0;
      wr(BCC_CTRL_OFS, {30'h0, m});
      for (int i = 0; i < 20 && s[BCC_ACK_BIT] !== 1'b1; i++) rd(BCC_STAT_OFS, s);
      wr(BCC_SCLR_OFS, 32'h1 << BCC_ACK_BIT);
   endtask
endmodule // bcc_host

/* File: bcc_pkg.sv */
package bcc_pkg;
   // Register byte offsets
   localparam logic [7:0] BCC_CTRL_OFS   = 8'h00;
   localparam logic [7:0] BCC_HMODE_OFS  = 8'h04;
   localparam logic [7:0] BCC_TIME_OFS   = 8'h08;
   localparam logic [7:0] BCC_CAL_OFS    = 8'h0c;
   localparam logic [7:0] BCC_TMATCH_OFS = 8'h10;
   localparam logic [7:0] BCC_CMATCH_OFS = 8'h14;
   localparam logic [7:0] BCC_STAT_OFS   = 8'h18;
   localparam logic [7:0] BCC_SCLR_OFS   = 8'h1c;
   localparam logic [7:0] BCC_IEN_OFS    = 8'h20;
   localparam logic [7:0] BCC_IDIS_OFS   = 8'h24;
   localparam logic [7:0] BCC_IMASK_OFS  = 8'h28;
   localparam logic [7:0] BCC_VALID_OFS  = 8'h2c;
   // Control word bits
   localparam int BCC_UPD_TIME_BIT = 0;
   localparam int BCC_UPD_CAL_BIT  = 1;
   // Status bits
   localparam int BCC_ACK_BIT   = 0;
   localparam int BCC_ALARM_BIT = 1;
   // Validity flag bits
   localparam int BCC_VT_BIT  = 0;
   localparam int BCC_VC_BIT  = 1;
   localparam int BCC_VTA_BIT = 2;
   localparam int BCC_VCA_BIT = 3;
   // Field enable bits of the match words, and the AM/PM bit of the hour field
   localparam int BCC_SEC_EN_BIT   = 7;
   localparam int BCC_MIN_EN_BIT   = 15;
   localparam int BCC_HOUR_EN_BIT  = 23;
   localparam int BCC_MONTH_EN_BIT = 23;
   localparam int BCC_DATE_EN_BIT  = 31;
   localparam int BCC_AMPM_BIT     = 22;
   // Values after reset
   localparam logic [31:0] BCC_CAL_RST  = 32'h0181_9819;
   localparam logic [31:0] BCC_TIME_RST = 32'h0000_0000;
   // Second tick from the system clock
   localparam int BCC_CLK_PERIOD_NS = 40;
   localparam int BCC_SECOND_NS     = 1_000_000_000;
   localparam int BCC_TICK_CYCLES   = BCC_SECOND_NS / BCC_CLK_PERIOD_NS;
   localparam int BCC_TICK_W        = 25;
endpackage

/* File: tb_bcc_clock.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module tb_bcc_clock;
   import bcc_pkg::*;
   localparam int TICK = 8;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        irq;
   logic [31:0] v;
   logic [31:0] w;
   int          n;
   int          mismatches = 0;
   int          compares = 0;
   logic [31:0] bad_t [6] = '{32'h60, 32'h5a, 32'h6000, 32'h24_0000, 32'h40_0000, 32'h1a_0000};
   logic [31:0] bad_c [7] = '{32'h3022_9919, 32'h2922_9919, 32'h0121_9921, 32'h0101_9919,
                              32'h0133_9919, 32'h0121_9a19, 32'h3221_9919};
   always #20 clk_sys = ~clk_sys;
   bcc_clock #(.TICK_CYCLES(TICK)) i_dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   bcc_host i_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   // Compare and count
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   // Wait a bounded time for the interrupt
   task automatic wait_irq(output int c);
      c = 0;
      while (irq !== 1'b1 && c < 70 * TICK) begin
         @(posedge clk_sys);
         c++;
      end
   endtask
   task automatic close_out;
      $display("Compares %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (6000) @(posedge clk_sys);
      mismatches++;
      close_out();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      i_host.rd(BCC_TIME_OFS, v);
      `CHK("reset time", BCC_TIME_RST, v);
      i_host.rd(BCC_CAL_OFS, v);
      `CHK("reset calendar", BCC_CAL_RST, v);
      i_host.rd(8'h30, v);
      `CHK("unmapped", 32'h0, v);
      // Stop time and load it
      i_host.upd(2'b01, v);
      `CHK("ack", 1'b1, v[BCC_ACK_BIT]);
      i_host.wr(BCC_TIME_OFS, 32'h0023_5958);
      repeat (3 * TICK) @(posedge clk_sys);
      i_host.rd(BCC_TIME_OFS, v);
      `CHK("halted time", 32'h0023_5958, v);
      // Illegal time words are dropped and flagged
      foreach (bad_t[i]) begin
         i_host.wr(BCC_TIME_OFS, bad_t[i]);
         i_host.rd(BCC_VALID_OFS, v);
         `CHK("time flag", 1'b1, v[BCC_VT_BIT]);
         i_host.rd(BCC_TIME_OFS, v);
         `CHK("time kept", 32'h0023_5958, v);
      end
      // Twelve-hour entry reads back as 24-hour
      i_host.wr(BCC_HMODE_OFS, 32'h1);
      i_host.wr(BCC_TIME_OFS, 32'h0041_1000);
      i_host.rd(BCC_VALID_OFS, v);
      `CHK("time flag clear", 1'b0, v[BCC_VT_BIT]);
      i_host.rd(BCC_TIME_OFS, v);
      `CHK("pm readback", 32'h0013_1000, v);
      i_host.wr(BCC_TIME_OFS, 32'h0013_0000);
      i_host.rd(BCC_TIME_OFS, v);
      `CHK("12h range", 32'h0013_1000, v);
      i_host.wr(BCC_HMODE_OFS, 32'h0);
      // Stop calendar too; illegal dates are dropped
      i_host.wr(BCC_CTRL_OFS, 32'h0);
      i_host.upd(2'b11, v);
      foreach (bad_c[i]) begin
         i_host.wr(BCC_CAL_OFS, bad_c[i]);
         i_host.rd(BCC_VALID_OFS, v);
         `CHK("cal flag", 1'b1, v[BCC_VC_BIT]);
         i_host.rd(BCC_CAL_OFS, v);
         `CHK("cal kept", BCC_CAL_RST, v);
      end
      i_host.wr(BCC_CAL_OFS, 32'h2922_0020);
      i_host.rd(BCC_CAL_OFS, v);
      `CHK("leap day", 32'h2922_0020, v);
      // Run across midnight into the new century
      i_host.wr(BCC_CAL_OFS, 32'h31f2_9919);
      i_host.wr(BCC_TIME_OFS, 32'h0023_5958);
      i_host.wr(BCC_CTRL_OFS, 32'h0);
      w = 32'h0023_5958;
      for (int i = 0; i < 30 && w[21:16] !== 6'h00; i++) i_host.rd2(BCC_TIME_OFS, w);
      `CHK("midnight", 32'h0, w);
      i_host.rd(BCC_CAL_OFS, v);
      `CHK("new century", 32'h0121_0020, v);
      `CHK("day wrap", 3'h1, v[23:21]);
      // Time keeps running during a calendar update
      i_host.upd(2'b10, v);
      i_host.rd2(BCC_TIME_OFS, w);
      repeat (3 * TICK) @(posedge clk_sys);
      i_host.rd2(BCC_TIME_OFS, v);
      `CHK("time runs", 1'b1, v !== w);
      i_host.wr(BCC_CTRL_OFS, 32'h0);
      // Illegal match words flagged apart
      i_host.wr(BCC_TMATCH_OFS, 32'h0000_00e0);
      i_host.wr(BCC_CMATCH_OFS, 32'h0093_0000);
      i_host.rd(BCC_VALID_OFS, v);
      `CHK("match flags", 4'hc, v[3:0]);
      // Seconds-only alarm with its interrupt
      i_host.wr(BCC_TMATCH_OFS, 32'h0000_0085);
      i_host.wr(BCC_CMATCH_OFS, 32'h0101_0000);
      i_host.wr(BCC_SCLR_OFS, 32'h3);
      i_host.wr(BCC_IEN_OFS, 32'h1 << BCC_ALARM_BIT);
      i_host.rd(BCC_IMASK_OFS, v);
      `CHK("mask", 32'h2, v);
      wait_irq(n);
      i_host.rd(BCC_TIME_OFS, v);
      `CHK("alarm second", 7'h05, v[6:0]);
      i_host.wr(BCC_SCLR_OFS, 32'h1 << BCC_ALARM_BIT);
      repeat (10 * TICK) @(posedge clk_sys);
      `CHK("single alarm", 1'b0, irq);
      wait_irq(n);
      `CHK("once a minute", 1'b1, n > 45 * TICK && n < 62 * TICK);
      // Masked interrupt, flag still set
      i_host.wr(BCC_IDIS_OFS, 32'h1 << BCC_ALARM_BIT);
      i_host.rd(BCC_STAT_OFS, v);
      `CHK("masked irq", 1'b0, irq);
      `CHK("alarm flag", 1'b1, v[BCC_ALARM_BIT]);
      // A non-matching enabled minute blocks the alarm
      i_host.wr(BCC_TMATCH_OFS, 32'h0000_a585);
      i_host.wr(BCC_SCLR_OFS, 32'h3);
      repeat (62 * TICK) @(posedge clk_sys);
      i_host.rd(BCC_STAT_OFS, v);
      `CHK("minute gate", 1'b0, v[BCC_ALARM_BIT]);
      close_out();
   end
endmodule // tb_bcc_clock
